// ---- src/acr_adc_control.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Flag mode: set done per conversion, continuous once
// - Status write or result read clears flag
// - Irq mode: flag bit selects DMA or CPU
// - Interrupt request at conversion end when enabled
// - Status write or result read drops request
// - Reset clears interrupt enable
// - Continuous bit repeats conversions, else one
// - Five-bit channel: ten pins, three references
// - All-ones channel powers converter off
// - Unused channel codes give unspecified result
// - Eight-bit result loaded at each completion
// - Prescaler divides by 1, 2, 4, 8, 16
// - Source bit: 1 bus, 0 oscillator
// - Status write starts a conversion unless its channel is all-ones
// - Conversion lasts 16 conversion clocks
// - Continuous results overwrite unread results
// - Selected pin forced input, reads zero
module acr_adc_control (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic osc_clk_i,
    input wire logic comp_i,
    output logic [4:0] chan_sel_o,
    output logic power_off_o,
    output logic [7:0] dac_code_o,
    output logic [2:0] ref_node_o,
    output logic [9:0] pin_analog_o,
    input wire logic [9:0] port_rd_i,
    output logic [9:0] port_rd_o,
    output logic cpu_irq_o,
    output logic dma_irq_o
);

    function automatic logic [9:0] pin_decode(input logic [4:0] ch);
        logic [9:0] v;
        v = '0;
        for (int i = 0; i < acr_pkg::PIN_COUNT; i++) begin
            if (ch == 5'(i)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction

    function automatic logic [3:0] div_last(input logic [2:0] code);
        logic [3:0] v;
        v = 4'hf;
        unique case (code)
            3'h0: v = 4'h0;
            3'h1: v = 4'h1;
            3'h2: v = 4'h3;
            3'h3: v = 4'h7;
            default: v = 4'hf;
        endcase
        return v;
    endfunction

    // Bus decode
    logic setup;
    logic acc_wr;
    logic acc_rd;
    logic hit_sc;
    logic hit_res;
    logic hit_clk;
    logic mapped;
    logic wr_sc;
    logic wr_clk;
    logic rd_res;

    assign hit_sc = paddr_i == acr_pkg::ADDR_SC;
    assign hit_res = paddr_i == acr_pkg::ADDR_RES;
    assign hit_clk = paddr_i == acr_pkg::ADDR_CLK;
    assign mapped = hit_sc | hit_res | hit_clk;
    assign setup = psel_i & ~penable_i;
    assign acc_wr = psel_i & penable_i & pwrite_i;
    assign acc_rd = psel_i & penable_i & ~pwrite_i;
    assign wr_sc = acc_wr & hit_sc;
    assign wr_clk = acc_wr & hit_clk;
    assign rd_res = acc_rd & hit_res;
    // Zero wait states; unmapped or misaligned words answer with an error
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // State
    logic flag_reg, flag_next;
    logic ien_reg, ien_next;
    logic cont_reg, cont_next;
    logic [4:0] ch_reg, ch_next;
    logic [2:0] div_reg, div_next;
    logic src_reg, src_next;
    logic [7:0] result_reg, result_next;
    logic [7:0] trial_reg, trial_next;
    logic [3:0] step_reg, step_next;
    acr_pkg::acr_state_t state_reg, state_next;
    logic first_reg, first_next;
    logic irq_reg, irq_next;
    logic [3:0] pre_reg, pre_next;
    logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic [9:0] pin_reg;
    logic [2:0] ref_reg;
    logic off_reg;

    logic src_tick;
    logic conv_tick;
    logic done_evt;
    logic start;
    logic wr_ien;
    logic [2:0] bit_idx;

    // Oscillator edge becomes an enable; first stage feeds only the second
    assign src_tick = (src_reg == acr_pkg::SRC_BUS) ? 1'b1 : (osc_s2_reg & ~osc_s3_reg);
    // Compare with >= so a smaller divider after a larger one never waits for a wrap
    assign conv_tick = src_tick && (pre_reg >= div_last(div_reg));
    assign done_evt = (state_reg == acr_pkg::ACR_CONV) && conv_tick
        && (step_reg == acr_pkg::STEP_LAST);
    assign wr_ien = pwdata_i[acr_pkg::IEN_BIT];
    // Power-off code in the written value blocks the start
    assign start = wr_sc && (pwdata_i[acr_pkg::CH_MSB:0] != acr_pkg::CH_OFF);
    assign bit_idx = 3'(acr_pkg::SAR_BITS - 1) - 3'(step_reg[3:1]);

    always_comb begin
        pre_next = pre_reg;
        // A start restarts the prescaler so every conversion clock is a full one
        if (wr_sc) begin
            pre_next = '0;
        end else if (src_tick) begin
            pre_next = conv_tick ? 4'h0 : pre_reg + 4'h1;
        end
    end

    // Control registers
    always_comb begin
        ien_next = ien_reg;
        cont_next = cont_reg;
        ch_next = ch_reg;
        div_next = div_reg;
        src_next = src_reg;
        if (wr_sc) begin
            ien_next = wr_ien;
            cont_next = pwdata_i[acr_pkg::CONT_BIT];
            ch_next = pwdata_i[acr_pkg::CH_MSB:0];
        end
        if (wr_clk) begin
            div_next = pwdata_i[acr_pkg::DIV_MSB:acr_pkg::DIV_LSB];
            src_next = pwdata_i[acr_pkg::SRC_BIT];
        end
    end

    // Sequencer: a status write restarts, the power-off code aborts
    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        trial_next = trial_reg;
        result_next = result_reg;
        first_next = first_reg;
        if (state_reg == acr_pkg::ACR_CONV && conv_tick) begin
            step_next = step_reg + 4'h1;
            if (!step_reg[0]) begin
                trial_next[bit_idx] = 1'b1;
            end else if (!comp_i) begin
                trial_next[bit_idx] = 1'b0;
            end
        end
        if (done_evt) begin
            result_next = trial_next;
            first_next = 1'b1;
            trial_next = '0;
            step_next = '0;
            if (!(cont_reg && ch_reg != acr_pkg::CH_OFF)) begin
                state_next = acr_pkg::ACR_IDLE;
            end
        end
        if (wr_sc) begin
            first_next = 1'b0;
            trial_next = '0;
            step_next = '0;
            state_next = start ? acr_pkg::ACR_CONV : acr_pkg::ACR_IDLE;
        end
    end

    // Flag and request; a completion in the clearing cycle wins
    always_comb begin
        flag_next = flag_reg;
        irq_next = irq_reg;
        if (wr_sc) begin
            flag_next = wr_ien ? pwdata_i[acr_pkg::FLAG_BIT] : 1'b0;
        end else if (rd_res && !ien_reg) begin
            flag_next = 1'b0;
        end
        if (done_evt && !ien_next && !(cont_reg && first_reg)) begin
            flag_next = 1'b1;
        end
        if (wr_sc || rd_res) begin
            irq_next = 1'b0;
        end
        if (done_evt && ien_reg) begin
            irq_next = 1'b1;
        end
    end

    always_comb begin
        prdata_next = prdata_reg;
        if (setup) begin
            prdata_next = '0;
            unique case (1'b1)
                hit_sc: prdata_next[7:0] = {flag_reg, ien_reg, cont_reg, ch_reg};
                hit_res: prdata_next[7:0] = result_reg;
                hit_clk: prdata_next[7:0] = {div_reg, src_reg, 4'h0};
                default: prdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            flag_reg <= 1'b0;
            ien_reg <= 1'b0;
            cont_reg <= 1'b0;
            ch_reg <= acr_pkg::CH_RESET;
            div_reg <= acr_pkg::DIV_RESET;
            src_reg <= acr_pkg::SRC_RESET;
            result_reg <= acr_pkg::RESULT_RESET;
            trial_reg <= '0;
            step_reg <= '0;
            state_reg <= acr_pkg::ACR_IDLE;
            first_reg <= 1'b0;
            irq_reg <= 1'b0;
            pre_reg <= '0;
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
            prdata_reg <= '0;
            pin_reg <= '0;
            ref_reg <= '0;
            off_reg <= 1'b1;
        end else begin
            flag_reg <= flag_next;
            ien_reg <= ien_next;
            cont_reg <= cont_next;
            ch_reg <= ch_next;
            div_reg <= div_next;
            src_reg <= src_next;
            result_reg <= result_next;
            trial_reg <= trial_next;
            step_reg <= step_next;
            state_reg <= state_next;
            first_reg <= first_next;
            irq_reg <= irq_next;
            pre_reg <= pre_next;
            osc_s1_reg <= osc_clk_i;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
            prdata_reg <= prdata_next;
            pin_reg <= pin_decode(ch_next);
            ref_reg <= {ch_next == acr_pkg::CH_2REFL, ch_next == acr_pkg::CH_CAP,
                ch_next == acr_pkg::CH_2CAP};
            off_reg <= ch_next == acr_pkg::CH_OFF;
        end
    end

    assign prdata_o = prdata_reg;
    assign chan_sel_o = ch_reg;
    assign power_off_o = off_reg;
    assign dac_code_o = trial_reg;
    assign ref_node_o = ref_reg;
    assign pin_analog_o = pin_reg;
    // Port logic must also ignore its own writes for the selected pin
    assign port_rd_o = port_rd_i & ~pin_reg;
    assign cpu_irq_o = irq_reg & ~flag_reg;
    assign dma_irq_o = irq_reg & flag_reg;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    property p_flag_set;
        done_evt && !ien_next && !cont_reg |=> flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_flag_cont;
        done_evt && !wr_sc && !rd_res && cont_reg && first_reg && !flag_reg |=> !flag_reg;
    endproperty
    a_flag_cont: assert property (p_flag_cont) else $error("flag set again");

    property p_flag_clr;
        (wr_sc && !wr_ien || rd_res && !ien_reg && !wr_sc) && !done_evt |=> !flag_reg;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

    property p_sel_wr;
        wr_sc && wr_ien |=> flag_reg == $past(pwdata_i[acr_pkg::FLAG_BIT]);
    endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("select not stored");

    property p_irq_cause;
        $rose(irq_reg) |-> $past(done_evt && ien_reg);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

    property p_irq_drop;
        (wr_sc || rd_res) && !done_evt |=> !cpu_irq_o && !dma_irq_o;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq not dropped");

    property p_reset;
        @(posedge sys_clk_i) disable iff (1'b0)
            srst_i |=> !ien_reg && !cont_reg && !flag_reg && !irq_reg;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");

    property p_single;
        done_evt && !cont_reg && !wr_sc |=> state_reg == acr_pkg::ACR_IDLE;
    endproperty
    a_single: assert property (p_single) else $error("single did not stop");

    property p_result;
        done_evt |=> result_reg == {$past(trial_reg[7:1]), $past(comp_i)} && trial_reg == 8'h00;
    endproperty
    a_result: assert property (p_result) else $error("result not loaded");

    property p_off;
        ch_reg == acr_pkg::CH_OFF && !wr_sc |=> power_off_o && state_reg == acr_pkg::ACR_IDLE
            && !$rose(irq_reg);
    endproperty
    a_off: assert property (p_off) else $error("off code active");

    property p_bus_div1;
        src_reg && div_reg == 3'h0 |-> conv_tick;
    endproperty
    a_bus_div1: assert property (p_bus_div1) else $error("div1 tick missing");

    property p_bus_conv;
        start && src_reg && div_reg == 3'h0 ##1 !acc_wr [*8] ##1 !acc_wr [*7]
            |=> done_evt;
    endproperty
    a_bus_conv: assert property (p_bus_conv) else $error("conversion length");

    property p_pin;
        ch_reg < 5'(acr_pkg::PIN_COUNT) && $stable(ch_reg) |-> port_rd_o[ch_reg[3:0]] == 1'b0;
    endproperty
    a_pin: assert property (p_pin) else $error("pin read not zero");

    c_done: cover property (done_evt && !ien_reg);
    c_irq_dma: cover property ($rose(dma_irq_o));
    c_cont: cover property (done_evt && cont_reg ##[1:600] done_evt);
    c_osc: cover property (done_evt && !src_reg);

endmodule

// ---- src/acr_pkg.sv ----
package acr_pkg;
    // Register byte addresses
    localparam logic [11:0] ADDR_SC = 12'h000;
    localparam logic [11:0] ADDR_RES = 12'h004;
    localparam logic [11:0] ADDR_CLK = 12'h008;
    localparam logic [1:0] ADDR_ALIGN = 2'h0;

    // status_control_reg layout
    localparam int FLAG_BIT = 7;
    localparam int IEN_BIT = 6;
    localparam int CONT_BIT = 5;
    localparam int CH_MSB = 4;
    localparam logic [4:0] CH_RESET = 5'h1f;
    localparam logic [4:0] CH_OFF = 5'h1f;
    localparam logic [4:0] CH_2CAP = 5'h1c;
    localparam logic [4:0] CH_CAP = 5'h1d;
    localparam logic [4:0] CH_2REFL = 5'h1e;
    localparam int PIN_COUNT = 10;

    // clock_select_reg layout
    localparam int DIV_MSB = 7;
    localparam int DIV_LSB = 5;
    localparam int SRC_BIT = 4;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic SRC_BUS = 1'b1;
    localparam logic SRC_RESET = 1'b0;

    // Conversion sequencing
    localparam int SAR_BITS = 8;
    localparam logic [3:0] STEP_LAST = 4'hf;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_CONV = 2'b01
    } acr_state_t;
endpackage

// ---- src/acr_unused_placeholder_none.sv ----
`timescale 1ns/1ps

// ---- dv/acr_analog_model.sv ----
`timescale 1ns/1ps
module acr_analog_model (
    input wire logic sys_clk_i,
    input wire logic [4:0] chan_sel_i,
    input wire logic power_off_i,
    input wire logic [7:0] dac_code_i,
    input wire logic [7:0] offset_i,
    output logic comp_o
);
    logic [7:0] vin;
    logic flip_reg = 1'b0;
    // Each channel sits at its own level, so a wrong mux choice shows in the result
    assign vin = {chan_sel_i, 3'h5} + offset_i;
    always_ff @(posedge sys_clk_i) begin
        flip_reg <= ~flip_reg;
    end
    // Powered off the comparator means nothing, so it toggles every cycle
    assign comp_o = power_off_i ? flip_reg : (vin >= dac_code_i);
endmodule

// ---- dv/test_adc_control_registers.sv ----
`timescale 1ns/1ps
module test_adc_control_registers;
    typedef struct {logic [4:0] ch; logic src; logic [2:0] dv; logic sel; int lo; int hi;} acr_row_t;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, osc = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [9:0] port_rd = 10'h3ff;
    logic [7:0] offset = 8'h00;
    logic rerr, comp;
    logic [31:0] prdata;
    logic pready, pslverr, power_off, cpu_irq, dma_irq;
    logic [4:0] chan_sel;
    logic [7:0] dac;
    logic [2:0] refs;
    logic [9:0] pins, port_out;
    int n_fail = 0, checked = 0, n;
    acr_row_t rows[7] = '{'{5'h00, 1, 3'h0, 0, 16, 18}, '{5'h09, 1, 3'h1, 1, 32, 35},
        '{5'h1c, 1, 3'h2, 0, 64, 69}, '{5'h1d, 1, 3'h3, 1, 128, 137},
        '{5'h1e, 1, 3'h4, 0, 256, 273}, '{5'h05, 1, 3'h7, 1, 256, 273},
        '{5'h02, 0, 3'h0, 0, 40, 90}};
    always #5 clk = ~clk;
    // Oscillator runs free at an unrelated rate
    always #17 osc = ~osc;
    acr_adc_control i_dut (.sys_clk_i(clk), .srst_i(rst), .paddr_i(paddr), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .osc_clk_i(osc), .comp_i(comp),
        .chan_sel_o(chan_sel), .power_off_o(power_off), .dac_code_o(dac), .ref_node_o(refs),
        .pin_analog_o(pins), .port_rd_i(port_rd), .port_rd_o(port_out),
        .cpu_irq_o(cpu_irq), .dma_irq_o(dma_irq));
    acr_analog_model i_model (.sys_clk_i(clk), .chan_sel_i(chan_sel), .power_off_i(power_off),
        .dac_code_i(dac), .offset_i(offset), .comp_o(comp));
    task print_verdict;
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk("pready", 1, 0);
            print_verdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wait_irq;
        for (n = 1; n <= 400; n++) begin
            @(posedge clk);
            if (cpu_irq === 1'b1 || dma_irq === 1'b1) break;
        end
        if (n > 400) begin
            chk("irq wait", 1, 0);
            print_verdict();
        end
    endtask
    task poll_flag;
        int i;
        for (i = 0; i < 40; i++) begin
            apb(0, acr_pkg::ADDR_SC, 8'h00);
            if (rdat[7] === 1'b1) break;
        end
        if (i == 40) begin
            chk("flag wait", 1, 0);
            print_verdict();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(0, acr_pkg::ADDR_SC, 8'h00);
        chk("status reset", 32'h1f, rdat);
        apb(0, acr_pkg::ADDR_CLK, 8'h00);
        chk("clock reset", 32'h00, rdat);
        chk("power off", 1, power_off);
        apb(1, acr_pkg::ADDR_CLK, 8'h10);
        apb(1, acr_pkg::ADDR_SC, 8'h00);
        // Discard the first conversion after leaving power off
        repeat (40) @(posedge clk);
        apb(0, acr_pkg::ADDR_RES, 8'h00);
        foreach (rows[k]) begin
            apb(1, acr_pkg::ADDR_CLK, {rows[k].dv, rows[k].src, 4'h0});
            apb(1, acr_pkg::ADDR_SC, {rows[k].sel, 2'b10, rows[k].ch});
            // Registered outputs settle after the write edge
            @(negedge clk);
            chk("chan_sel", rows[k].ch, chan_sel);
            if (rows[k].ch < 5'h0a) begin
                chk("pin", 10'h1 << rows[k].ch, pins);
                chk("port read", 10'h3ff & ~(10'h1 << rows[k].ch), port_out);
            end else begin
                chk("ref node", 3'h1 << (rows[k].ch - 5'h1c), refs);
            end
            wait_irq();
            chk("conv time", 1, n >= rows[k].lo && n <= rows[k].hi);
            chk("irq route", rows[k].sel ? 2'b10 : 2'b01, {dma_irq, cpu_irq});
            apb(0, acr_pkg::ADDR_RES, 8'h00);
            chk("result", {rows[k].ch, 3'h5}, rdat);
            @(posedge clk);
            chk("irq after read", 0, {dma_irq, cpu_irq});
        end
        apb(1, acr_pkg::ADDR_CLK, 8'h10);
        apb(1, acr_pkg::ADDR_SC, 8'h03);
        poll_flag();
        chk("flag irqs", 0, {dma_irq, cpu_irq});
        apb(0, acr_pkg::ADDR_SC, 8'h00);
        chk("flag holds", 32'h83, rdat);
        apb(0, acr_pkg::ADDR_RES, 8'h00);
        chk("single result", 32'h1d, rdat);
        apb(0, acr_pkg::ADDR_SC, 8'h00);
        chk("flag cleared by read", 32'h03, rdat);
        apb(1, acr_pkg::ADDR_SC, 8'h03);
        poll_flag();
        apb(1, acr_pkg::ADDR_SC, 8'h5f);
        repeat (40) @(posedge clk);
        apb(0, acr_pkg::ADDR_SC, 8'h00);
        chk("off status", 32'h5f, rdat);
        chk("off irqs", 0, {dma_irq, cpu_irq});
        apb(1, acr_pkg::ADDR_SC, 8'h25);
        poll_flag();
        apb(0, acr_pkg::ADDR_RES, 8'h00);
        chk("cont result", 32'h2d, rdat);
        offset <= 8'h10;
        repeat (60) @(posedge clk);
        apb(0, acr_pkg::ADDR_SC, 8'h00);
        chk("cont flag once", 32'h25, rdat);
        apb(0, acr_pkg::ADDR_RES, 8'h00);
        chk("cont overwrite", 32'h3d, rdat);
        apb(1, acr_pkg::ADDR_SC, 8'h44);
        wait_irq();
        apb(1, acr_pkg::ADDR_SC, 8'h04);
        @(posedge clk);
        chk("irq after write", 0, {dma_irq, cpu_irq});
        apb(0, 12'h00c, 8'h00);
        chk("unmapped err", 1, rerr);
        chk("unmapped data", 0, rdat);
        apb(1, acr_pkg::ADDR_SC, 8'h45);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(0, acr_pkg::ADDR_SC, 8'h00);
        chk("status mid reset", 32'h1f, rdat);
        chk("irqs mid reset", 0, {dma_irq, cpu_irq});
        print_verdict();
    end
endmodule
